// *** pkg/pei_pkg.sv ***
// Shared constants and types for the PHY extended status and indirect block
package pei_pkg;

  // Clause 22 register offsets
  localparam logic [4:0] REG_ABILITY = 5'h0f;
  localparam logic [4:0] REG_IND_PTR = 5'h10;
  localparam logic [4:0] REG_IND_DATA = 5'h11;
  localparam logic [4:0] REG_XDIAG = 5'h12;

  // Reset and fixed values
  localparam logic [15:0] ABILITY_VALUE = 16'h0000;
  localparam logic [15:0] IND_PTR_RESET = 16'h0000;
  localparam logic [15:0] IND_DATA_RESET = 16'h0000;
  localparam logic [15:0] XDIAG_RESET = 16'h0002;

  // Field positions in crossover_diag_control
  localparam int AUTO_XOVER_BIT = 10;
  localparam int MAN_XOVER_BIT = 9;
  localparam int DIAG_CLK_BIT = 2;
  localparam int RSV_LOW_MSB = 1;
  localparam int RSV_LOW_LSB = 0;
  localparam logic [1:0] RSV_LOW_RESET = 2'h2;

  // Management frame layout
  localparam logic [5:0] PREAMBLE_BITS = 6'h20;
  localparam logic [5:0] HDR_BITS = 6'h0d;
  localparam logic [5:0] DATA_BITS = 6'h10;
  localparam logic [1:0] C22_OP_WRITE = 2'h1;
  localparam logic [1:0] C22_OP_READ = 2'h2;
  localparam logic [1:0] C45_OP_ADDR = 2'h0;
  localparam logic [1:0] C45_OP_WRITE = 2'h1;
  localparam logic [1:0] C45_OP_READ_INC = 2'h2;
  localparam logic [1:0] C45_OP_READ = 2'h3;

  // Station and device addresses of this port
  localparam logic [4:0] PHY_ADDR = 5'h00;
  localparam logic [4:0] MMD_DEVAD = 5'h1e;

  // Indirect register space
  localparam int EXT_DEPTH = 8;
  localparam int EXT_AW = 3;
  localparam logic [15:0] EXT_LIMIT = 16'h0008;

  // Auto crossover hunt interval
  localparam int CLK_MHZ = 200;
  localparam int HUNT_TIME_US = 10;
  localparam int HUNT_CYCLES = HUNT_TIME_US * CLK_MHZ;
  localparam logic [10:0] HUNT_LAST = 11'(HUNT_CYCLES - 1);

  typedef enum logic [1:0] {
    PEI_PRE,
    PEI_HDR,
    PEI_TA,
    PEI_DATA
  } pei_state_t;

endpackage : pei_pkg

// *** pkg/pei_xover_if.sv ***
// Crossover control and result between register bank and resolver
`timescale 1ns/100ps
`default_nettype none
interface pei_xover_if;
  logic auto_en;
  logic man_sel;
  logic link_good;
  logic mdix;

  modport ctrl (
    output auto_en,
    output man_sel,
    output link_good,
    input mdix
  );

  modport res (
    input auto_en,
    input man_sel,
    input link_good,
    output mdix
  );
endinterface : pei_xover_if
`default_nettype wire

// *** logic/pei_crossover.sv ***
// MDI/MDIX crossover resolver
`timescale 1ns/100ps
`default_nettype none
module pei_crossover (
  input wire logic clk_in,
  input wire logic rst_in,
  pei_xover_if.res xif
);

  logic mdix;
  logic prev_auto;
  logic [10:0] hunt_cnt;
  logic next_mdix;
  logic next_prev_auto;
  logic [10:0] next_hunt_cnt;

  always_comb begin
    next_mdix = mdix;
    next_prev_auto = xif.auto_en;
    next_hunt_cnt = hunt_cnt;
    if (!xif.auto_en) begin
      // Manual: 1 pairs swapped, 0 straight through
      next_mdix = xif.man_sel;
      next_hunt_cnt = 11'h000;
    end else if (!prev_auto) begin
      // Hunting starts from the preferred setting
      next_mdix = xif.man_sel;
      next_hunt_cnt = 11'h000;
    end else if (xif.link_good) begin
      next_hunt_cnt = 11'h000;
    end else if (hunt_cnt == pei_pkg::HUNT_LAST) begin
      // No link yet: try the other pairing
      next_mdix = ~mdix;
      next_hunt_cnt = 11'h000;
    end else begin
      next_hunt_cnt = hunt_cnt + 11'h001;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mdix <= 1'b0;
      prev_auto <= 1'b0;
      hunt_cnt <= 11'h000;
    end else begin
      mdix <= next_mdix;
      prev_auto <= next_prev_auto;
      hunt_cnt <= next_hunt_cnt;
    end
  end

  assign xif.mdix = mdix;

endmodule : pei_crossover
`default_nettype wire

// *** logic/pei_top.sv ***
// MDIO management slave with extended status, indirect access and crossover
`timescale 1ns/100ps
`default_nettype none
module pei_top (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic mdc_in,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_out,
  input wire logic auto_crossover_strap_in,
  input wire logic link_good_in,
  output logic mdix_out,
  output logic diagnostic_clock_enable_out
);

  pei_xover_if xif ();

  pei_pkg::pei_state_t state;
  pei_pkg::pei_state_t next_state;
  logic mdc_q;
  logic [5:0] cnt;
  logic [15:0] shreg;
  logic [15:0] rdata;
  logic [1:0] op;
  logic [4:0] regad;
  logic is_c45;
  logic hit;
  logic rd;
  logic mdio_o;
  logic mdio_oe;
  logic [15:0] ptr;
  logic [15:0] c45_addr;
  logic [15:0] ext_mem [pei_pkg::EXT_DEPTH];
  logic auto_en;
  logic man_sel;
  logic diag;
  logic [1:0] rsv_low;
  logic strap_done;

  logic [5:0] next_cnt;
  logic [15:0] next_shreg;
  logic [15:0] next_rdata;
  logic [1:0] next_op;
  logic [4:0] next_regad;
  logic next_is_c45;
  logic next_hit;
  logic next_rd;
  logic next_mdio_o;
  logic next_mdio_oe;
  logic [15:0] next_ptr;
  logic [15:0] next_c45_addr;
  logic [15:0] next_ext_mem [pei_pkg::EXT_DEPTH];
  logic next_auto_en;
  logic next_man_sel;
  logic next_diag;
  logic [1:0] next_rsv_low;
  logic next_strap_done;

  logic mdc_rise;
  logic [12:0] hdr;
  logic [15:0] wdata;
  logic [15:0] ctrl_word;
  logic [15:0] ind_word;
  logic [15:0] c45_word;
  logic [15:0] c22_word;

  assign mdc_rise = mdc_in & ~mdc_q;
  assign hdr = {shreg[11:0], mdio_in};
  assign wdata = {shreg[14:0], mdio_in};
  assign ctrl_word = {5'h00, auto_en, man_sel, 6'h00, diag, rsv_low};
  assign ind_word = (ptr < pei_pkg::EXT_LIMIT) ?
                    ext_mem[ptr[pei_pkg::EXT_AW-1:0]] : 16'h0000;
  assign c45_word = (c45_addr < pei_pkg::EXT_LIMIT) ?
                    ext_mem[c45_addr[pei_pkg::EXT_AW-1:0]] : 16'h0000;

  // Offsets outside this slice read as zero here
  always_comb begin
    unique case (hdr[4:0])
      pei_pkg::REG_ABILITY: c22_word = pei_pkg::ABILITY_VALUE;
      pei_pkg::REG_IND_PTR: c22_word = ptr;
      pei_pkg::REG_IND_DATA: c22_word = ind_word;
      pei_pkg::REG_XDIAG: c22_word = ctrl_word;
      default: c22_word = 16'h0000;
    endcase
  end

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_shreg = shreg;
    next_rdata = rdata;
    next_op = op;
    next_regad = regad;
    next_is_c45 = is_c45;
    next_hit = hit;
    next_rd = rd;
    next_mdio_o = mdio_o;
    next_mdio_oe = mdio_oe;
    next_ptr = ptr;
    next_c45_addr = c45_addr;
    next_ext_mem = ext_mem;
    next_auto_en = auto_en;
    next_man_sel = man_sel;
    next_diag = diag;
    next_rsv_low = rsv_low;
    next_strap_done = 1'b1;
    // Strap caught on the first edge after reset release
    if (!strap_done) begin
      next_auto_en = auto_crossover_strap_in;
    end
    if (mdc_rise) begin
      unique case (state)
        pei_pkg::PEI_PRE: begin
          if (mdio_in) begin
            if (cnt != pei_pkg::PREAMBLE_BITS) begin
              next_cnt = cnt + 6'h01;
            end
          end else if (cnt == pei_pkg::PREAMBLE_BITS) begin
            // First start bit seen; both clauses open with 0
            next_state = pei_pkg::PEI_HDR;
            next_cnt = 6'h00;
          end else begin
            next_cnt = 6'h00;
          end
        end
        pei_pkg::PEI_HDR: begin
          next_shreg = wdata;
          next_cnt = cnt + 6'h01;
          if (cnt == pei_pkg::HDR_BITS - 6'h01) begin
            next_state = pei_pkg::PEI_TA;
            next_cnt = 6'h00;
            next_is_c45 = ~hdr[12];
            next_op = hdr[11:10];
            next_regad = hdr[4:0];
            next_hit = (hdr[9:5] == pei_pkg::PHY_ADDR) &&
                       (hdr[12] || hdr[4:0] == pei_pkg::MMD_DEVAD);
            next_rd = next_hit && (hdr[12] ?
                      (hdr[11:10] == pei_pkg::C22_OP_READ) : hdr[11]);
            next_rdata = hdr[12] ? c22_word : c45_word;
            if (next_hit && !hdr[12] &&
                hdr[11:10] == pei_pkg::C45_OP_READ_INC) begin
              // Only the direct address steps; the pointer never does
              next_c45_addr = c45_addr + 16'h0001;
            end
          end
        end
        pei_pkg::PEI_TA: begin
          next_cnt = cnt + 6'h01;
          if (cnt == 6'h00) begin
            next_mdio_oe = rd;
            next_mdio_o = 1'b0;
          end else begin
            next_mdio_o = rd & rdata[15];
            next_rdata = {rdata[14:0], 1'b0};
            next_state = pei_pkg::PEI_DATA;
            next_cnt = 6'h00;
          end
        end
        pei_pkg::PEI_DATA: begin
          next_shreg = wdata;
          next_cnt = cnt + 6'h01;
          next_mdio_o = rd & rdata[15];
          next_rdata = {rdata[14:0], 1'b0};
          if (cnt == pei_pkg::DATA_BITS - 6'h01) begin
            next_state = pei_pkg::PEI_PRE;
            next_cnt = 6'h00;
            next_mdio_oe = 1'b0;
            next_mdio_o = 1'b0;
            next_rd = 1'b0;
            if (hit && !is_c45 && op == pei_pkg::C22_OP_WRITE) begin
              unique case (regad)
                pei_pkg::REG_IND_PTR: next_ptr = wdata;
                pei_pkg::REG_IND_DATA: begin
                  if (ptr < pei_pkg::EXT_LIMIT) begin
                    next_ext_mem[ptr[pei_pkg::EXT_AW-1:0]] = wdata;
                  end
                end
                pei_pkg::REG_XDIAG: begin
                  next_auto_en = wdata[pei_pkg::AUTO_XOVER_BIT];
                  next_man_sel = wdata[pei_pkg::MAN_XOVER_BIT];
                  next_diag = wdata[pei_pkg::DIAG_CLK_BIT];
                  next_rsv_low =
                    wdata[pei_pkg::RSV_LOW_MSB:pei_pkg::RSV_LOW_LSB];
                end
                default: begin
                end
              endcase
            end
            if (hit && is_c45 && op == pei_pkg::C45_OP_ADDR) begin
              next_c45_addr = wdata;
            end
            if (hit && is_c45 && op == pei_pkg::C45_OP_WRITE &&
                c45_addr < pei_pkg::EXT_LIMIT) begin
              next_ext_mem[c45_addr[pei_pkg::EXT_AW-1:0]] = wdata;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= pei_pkg::PEI_PRE;
      mdc_q <= 1'b0;
      cnt <= 6'h00;
      shreg <= 16'h0000;
      rdata <= 16'h0000;
      op <= 2'h0;
      regad <= 5'h00;
      is_c45 <= 1'b0;
      hit <= 1'b0;
      rd <= 1'b0;
      mdio_o <= 1'b0;
      mdio_oe <= 1'b0;
      ptr <= pei_pkg::IND_PTR_RESET;
      c45_addr <= 16'h0000;
      for (int i = 0; i < pei_pkg::EXT_DEPTH; i++) begin
        ext_mem[i] <= pei_pkg::IND_DATA_RESET;
      end
      auto_en <= pei_pkg::XDIAG_RESET[pei_pkg::AUTO_XOVER_BIT];
      man_sel <= pei_pkg::XDIAG_RESET[pei_pkg::MAN_XOVER_BIT];
      diag <= pei_pkg::XDIAG_RESET[pei_pkg::DIAG_CLK_BIT];
      rsv_low <= pei_pkg::RSV_LOW_RESET;
      strap_done <= 1'b0;
    end else begin
      state <= next_state;
      mdc_q <= mdc_in;
      cnt <= next_cnt;
      shreg <= next_shreg;
      rdata <= next_rdata;
      op <= next_op;
      regad <= next_regad;
      is_c45 <= next_is_c45;
      hit <= next_hit;
      rd <= next_rd;
      mdio_o <= next_mdio_o;
      mdio_oe <= next_mdio_oe;
      ptr <= next_ptr;
      c45_addr <= next_c45_addr;
      ext_mem <= next_ext_mem;
      auto_en <= next_auto_en;
      man_sel <= next_man_sel;
      diag <= next_diag;
      rsv_low <= next_rsv_low;
      strap_done <= next_strap_done;
    end
  end

  assign xif.auto_en = auto_en;
  assign xif.man_sel = man_sel;
  assign xif.link_good = link_good_in;

  pei_crossover pei_crossover_inst (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .xif(xif)
  );

  assign mdio_out = mdio_o;
  assign mdio_oe_out = mdio_oe;
  assign mdix_out = xif.mdix;
  assign diagnostic_clock_enable_out = diag;

endmodule : pei_top
`default_nettype wire

// *** verification/pei_monitor.sv ***
// Port-level checks for the extended status and indirect access block
`timescale 1ns/100ps
`default_nettype none
module pei_monitor (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic mdc_in,
  input wire logic mdio_in,
  input wire logic mdio_out,
  input wire logic mdio_oe_out,
  input wire logic auto_crossover_strap_in,
  input wire logic link_good_in,
  input wire logic mdix_out,
  input wire logic diagnostic_clock_enable_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Drive changes only follow a management clock rise
  sequence s_mdc_recent;
    $past(mdc_in) || $past(mdc_in, 2) || $past(mdc_in, 3);
  endsequence
  a_turn_low: assert property (
    $rose(mdio_oe_out) |-> !mdio_out) else $error("turnaround not low");
  a_oe_holds: assert property (
    $rose(mdio_oe_out) |-> mdio_oe_out [*8]) else $error("drive too short");
  a_oe_on_mdc: assert property (
    $rose(mdio_oe_out) |-> s_mdc_recent) else $error("drive without mdc");
  a_out_on_mdc: assert property (
    mdio_oe_out && $past(mdio_oe_out) && $changed(mdio_out) |-> s_mdc_recent)
    else $error("data moved without mdc");
  a_diag_quiet: assert property (
    $changed(diagnostic_clock_enable_out) |-> !mdio_oe_out)
    else $error("diag clock moved during read");
  a_diag_reset: assert property (
    $fell(rst_in) |-> !diagnostic_clock_enable_out [*8])
    else $error("diag clock on after reset");
  a_mdix_reset: assert property (
    $fell(rst_in) |-> !mdix_out [*8]) else $error("mdix after reset");
  a_reset_idle: assert property (
    $fell(rst_in) |-> !mdio_oe_out [*8]) else $error("drive after reset");
endmodule : pei_monitor
bind pei_top pei_monitor pei_monitor_inst (.clk_in(clk_in), .rst_in(rst_in),
  .mdc_in(mdc_in), .mdio_in(mdio_in), .mdio_out(mdio_out),
  .mdio_oe_out(mdio_oe_out),
  .auto_crossover_strap_in(auto_crossover_strap_in),
  .link_good_in(link_good_in), .mdix_out(mdix_out),
  .diagnostic_clock_enable_out(diagnostic_clock_enable_out));
`default_nettype wire

// *** verification/pei_mgr_model.sv ***
// Station manager model sending management frames from the host side
`timescale 1ns/100ps
`default_nettype none
module pei_mgr_model (
  input wire logic clk_in,
  input wire logic line_in,
  output logic mdc_out,
  output logic mdio_drv_out
);
  initial begin
    mdc_out = 1'b0;
    mdio_drv_out = 1'b1;
  end
  // Frame word: st op phy reg/dev ta data, sent after 32 ones
  task automatic frame(input logic [31:0] f, output logic [15:0] r);
    logic [63:0] bits;
    bits = {32'hffffffff, f};
    r = 16'h0000;
    for (int i = 0; i < 64; i++) begin
      @(posedge clk_in);
      mdc_out <= 1'b0;
      // Reads release at turnaround; the pull-up then shows ones
      mdio_drv_out <= (f[29] && i > 45) ? 1'b1 : bits[63 - i];
      repeat (4) @(posedge clk_in);
      if (i > 47) r[63 - i] = line_in;
      mdc_out <= 1'b1;
      repeat (3) @(posedge clk_in);
    end
    @(posedge clk_in);
    mdc_out <= 1'b0;
    mdio_drv_out <= 1'b1;
    repeat (4) @(posedge clk_in);
  endtask : frame
endmodule : pei_mgr_model
`default_nettype wire

// *** verification/tb_pei_top.sv ***
// Self-checking bench for the extended status and indirect access block
`timescale 1ns/100ps
`default_nettype none
module tb_pei_top;
  logic clk_in, rst_in, mdc, drv, strap, link_good;
  logic mdio_out, mdio_oe_out, mdix, diag, line;
  logic [31:0] seed;
  logic [15:0] mem [8];
  logic [15:0] v, got;
  int failures, tests_run, k;
  assign line = mdio_oe_out ? mdio_out : drv;
  pei_top pei_top_inst (.clk_in(clk_in), .rst_in(rst_in), .mdc_in(mdc),
    .mdio_in(line), .mdio_out(mdio_out), .mdio_oe_out(mdio_oe_out),
    .auto_crossover_strap_in(strap), .link_good_in(link_good),
    .mdix_out(mdix), .diagnostic_clock_enable_out(diag));
  pei_mgr_model pei_mgr_model_inst (.clk_in(clk_in), .line_in(line),
    .mdc_out(mdc), .mdio_drv_out(drv));
  function automatic logic [15:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction : xs
  // Writable bits of the control register: 10, 9, 2 and 1:0
  function automatic logic [15:0] ctl_exp(input logic [15:0] w);
    return w & 16'h0607;
  endfunction : ctl_exp
  task automatic chk16(input logic [15:0] g, e, input string what);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("BAD %0t %s got %h want %h", $time, what, g, e);
    end
  endtask : chk16
  task automatic chk1(input logic g, e, input string what);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("BAD %0t %s got %b want %b", $time, what, g, e);
    end
  endtask : chk1
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    pei_mgr_model_inst.frame({2'h1, pei_pkg::C22_OP_WRITE,
      pei_pkg::PHY_ADDR, ra, 2'h2, d}, got);
  endtask : wr
  task automatic rd(input logic [4:0] ra);
    pei_mgr_model_inst.frame({2'h1, pei_pkg::C22_OP_READ,
      pei_pkg::PHY_ADDR, ra, 2'h2, 16'h0000}, got);
  endtask : rd
  task automatic f45(input logic [1:0] op, input logic [15:0] d);
    pei_mgr_model_inst.frame({2'h0, op, pei_pkg::PHY_ADDR,
      pei_pkg::MMD_DEVAD, 2'h2, d}, got);
  endtask : f45
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  initial begin
    repeat (100000) @(posedge clk_in);
    failures++;
    end_of_test();
  end
  initial begin
    rst_in = 1'b1;
    strap = 1'b1;
    link_good = 1'b1;
    seed = 32'h000091a6;
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    rd(pei_pkg::REG_ABILITY);
    chk16(got, pei_pkg::ABILITY_VALUE, "extended_ability_status");
    rd(pei_pkg::REG_XDIAG);
    chk16(got, pei_pkg::XDIAG_RESET | 16'h0400, "ctl");
    chk1(mdix, 1'b0, "auto mdi");
    wr(pei_pkg::REG_ABILITY, 16'hffff);
    rd(pei_pkg::REG_ABILITY);
    chk16(got, 16'h0000, "extended_ability_status ro");
    // Second reset between frames, strap low this time
    strap <= 1'b0;
    rst_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    rd(pei_pkg::REG_XDIAG);
    chk16(got, pei_pkg::XDIAG_RESET, "ctl strap low");
    chk1(mdix, 1'b0, "manual mdi");
    $display("test reset done");
    for (k = 0; k < 6; k++) begin
      // Auto off so the manual select alone decides; low field kept at 2
      v = (xs() & 16'hfbfc) | 16'h0002;
      v = (k == 0) ? 16'h0202 : (k == 1) ? 16'hfbfe : (k == 2) ? 16'h0002 : v;
      wr(pei_pkg::REG_XDIAG, v);
      rd(pei_pkg::REG_XDIAG);
      chk16(got, ctl_exp(v), "ctl readback");
      chk1(mdix, v[9], "manual xover");
      chk1(diag, v[2], "diag clock");
    end
    link_good <= 1'b0;
    wr(pei_pkg::REG_XDIAG, 16'h0602);
    chk1(mdix, 1'b1, "auto mdix");
    repeat (2500) @(posedge clk_in);
    chk1(mdix, 1'b0, "hunt toggle");
    link_good <= 1'b1;
    repeat (3000) @(posedge clk_in);
    chk1(mdix, 1'b0, "link holds");
    $display("test crossover done");
    for (k = 0; k < 8; k++) begin
      mem[k] = xs();
      wr(pei_pkg::REG_IND_PTR, 16'(k));
      wr(pei_pkg::REG_IND_DATA, mem[k]);
    end
    for (k = 0; k < 8; k++) begin
      f45(pei_pkg::C45_OP_ADDR, 16'(k));
      f45(pei_pkg::C45_OP_READ, 16'h0000);
      chk16(got, mem[k], "direct read");
      wr(pei_pkg::REG_IND_PTR, 16'(k));
      rd(pei_pkg::REG_IND_DATA);
      chk16(got, mem[k], "indirect read");
      rd(pei_pkg::REG_IND_DATA);
      chk16(got, mem[k], "indirect again");
    end
    v = xs();
    f45(pei_pkg::C45_OP_ADDR, 16'h0006);
    f45(pei_pkg::C45_OP_WRITE, v);
    f45(pei_pkg::C45_OP_READ_INC, 16'h0000);
    chk16(got, v, "direct write");
    f45(pei_pkg::C45_OP_READ, 16'h0000);
    chk16(got, mem[7], "read increment");
    wr(pei_pkg::REG_IND_PTR, 16'h0006);
    rd(pei_pkg::REG_IND_DATA);
    chk16(got, v, "shared space");
    rd(pei_pkg::REG_IND_PTR);
    chk16(got, 16'h0006, "pointer held");
    // Pointer past the implemented space: writes dropped, reads zero
    wr(pei_pkg::REG_IND_PTR, 16'h0008);
    wr(pei_pkg::REG_IND_DATA, 16'h5a5a);
    rd(pei_pkg::REG_IND_DATA);
    chk16(got, 16'h0000, "ptr beyond space");
    // Another station address: line left to the pull-up
    pei_mgr_model_inst.frame({2'h1, pei_pkg::C22_OP_READ, 5'h01,
      pei_pkg::REG_IND_PTR, 2'h2, 16'h0000}, got);
    chk16(got, 16'hffff, "other phy silent");
    $display("test indirect done");
    end_of_test();
  end
endmodule : tb_pei_top
`default_nettype wire
